// File: src/ssp_pkg.sv
// Shared constants and types for the stop and plausibility monitor
package ssp_pkg;
   localparam int AW = 8;
   localparam int DW = 32;
   // Register byte offsets
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_DELAY = 8'h04;
   localparam logic [7:0] A_STHR = 8'h08;
   localparam logic [7:0] A_TOL = 8'h0c;
   localparam logic [7:0] A_HYST = 8'h10;
   localparam logic [7:0] A_VCUT = 8'h14;
   localparam logic [7:0] A_VLIM = 8'h18;
   localparam logic [7:0] A_RATIO = 8'h1c;
   localparam logic [7:0] A_MASK = 8'h20;
   localparam logic [7:0] A_STAT = 8'h24;
   localparam logic [7:0] A_STATE = 8'h28;
   localparam logic [7:0] A_POS = 8'h2c;
   localparam logic [7:0] A_SPEED = 8'h30;
   localparam int NCFG = 9;
   localparam int I_CTRL = 0;
   localparam int I_DELAY = 1;
   localparam int I_STHR = 2;
   localparam int I_TOL = 3;
   localparam int I_HYST = 4;
   localparam int I_VCUT = 5;
   localparam int I_VLIM = 6;
   localparam int I_RATIO = 7;
   localparam int I_MASK = 8;
   // Control bits
   localparam int C_STOP = 0;
   localparam int C_IDX = 1;
   localparam int C_POLA = 2;
   localparam int C_POLB = 3;
   localparam int C_PROX = 4;
   localparam int C_AUXE = 5;
   // Status bits
   localparam int NSTAT = 4;
   localparam int S_POS = 0;
   localparam int S_PLS = 1;
   localparam int S_SHP = 2;
   localparam int S_AUX = 3;
   localparam logic [31:0] CFG_RST = 32'h0000_0000;
   localparam logic [1:0] RESP_OK = 2'b00;
   localparam logic [1:0] RESP_ERR = 2'b10;
   // Timing
   localparam int CLK_MHZ = 100;
   localparam int WIN_US = 1000;
   localparam int WIN_CYC = WIN_US * CLK_MHZ;
   localparam int MIN_FREQ_MHZ = 10;
   localparam longint MIN_CYC =
      longint'(1000) * 64'd1000000 * CLK_MHZ / MIN_FREQ_MHZ;
   // Ratio is unsigned 8.8, tolerance figures doubled
   localparam logic [15:0] RATIO_ONE = 16'h0100;
   localparam logic [3:0] TOL_HI_X2 = 4'hf;
   localparam logic [3:0] TOL_LO_X2 = 4'h9;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_BRAKE = 2'b01,
      ST_HOLD = 2'b11,
      ST_TRIP = 2'b10
   } ssp_stop_e;
endpackage

// File: src/ssp_sync.sv
// Two-flop synchroniser for asynchronous track inputs
`timescale 1ns/10ps
module ssp_sync #(
   parameter int W = 1
) (
   input wire logic aclk,            // Clock
   input wire logic aresetn,         // Sync reset, active low
   input wire logic [W-1:0] d,       // Asynchronous input
   output logic [W-1:0] q            // Synchronised output
);
   logic [W-1:0] s1_r;
   logic [W-1:0] s2_r;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s1_r <= '0;
         s2_r <= '0;
      end else begin
         s1_r <= d;
         s2_r <= s1_r;
      end
   end

   assign q = s2_r;
endmodule

// File: src/ssp_top.sv
// Controlled stop with standstill hold and track plausibility
// Function
// - On stop trigger, braking-ramp output goes off at once.
// - Hold start turns position output on; violation turns it and torque off.
// - Without threshold, hold starts exactly when braking delay expires.
// - With threshold, hold starts once speed falls below it.
// - During hold with encoder tracks, leaving the tolerance window removes torque.
// - Configurable hysteresis applies while a monitor output is on.
// - A validation cut-off frequency is held for proximity switches.
// - Below the cut-off, track plausibility checking is suspended.
// - Any of four polarity combinations is selectable for the tracks.
// - Auxiliary voltage is checked against upper and lower limits.
// - Alternatively auxiliary input is an encoder error, a sensor fault.
// - Index proximity switch checked against quadrature for broken shearpin.
// - Shearpin check only after minimum speed and tolerance elapsed.
// - Tolerance is 7.5 pulses scaled by ratio, or a fixed 4.5 pulses when ratio is below one.
// - Index handling is on or off by configuration.
`timescale 1ns/10ps
module ssp_top #(
   parameter int WIN_CYCLES = ssp_pkg::WIN_CYC,
   parameter longint MIN_CYCLES = ssp_pkg::MIN_CYC
) (
   input wire logic aclk,                         // Clock, 100 MHz
   input wire logic aresetn,                      // Sync reset, low
   input wire logic [ssp_pkg::AW-1:0] awaddr,     // Write address
   input wire logic awvalid,                      // Write addr valid
   output logic awready,                          // Write addr ready
   input wire logic [ssp_pkg::DW-1:0] wdata,      // Write data
   input wire logic [3:0] wstrb,                  // Byte enables
   input wire logic wvalid,                       // Write data valid
   output logic wready,                           // Write data ready
   output logic [1:0] bresp,                      // Write response
   output logic bvalid,                           // Response valid
   input wire logic bready,                       // Response ready
   input wire logic [ssp_pkg::AW-1:0] araddr,     // Read address
   input wire logic arvalid,                      // Read addr valid
   output logic arready,                          // Read addr ready
   output logic [ssp_pkg::DW-1:0] rdata,          // Read data
   output logic [1:0] rresp,                      // Read response
   output logic rvalid,                           // Read data valid
   input wire logic rready,                       // Read data ready
   input wire logic trk_a,                        // Track A pin
   input wire logic trk_b,                        // Track B pin
   input wire logic trk_z,                        // Index track pin
   input wire logic trk_aux,                      // Aux error pin
   input wire logic [11:0] aux_volt,              // Aux voltage code
   output logic brake_ramp_on,                    // High: no braking
   output logic pos_mon_on,                       // Position monitoring
   output logic torque_on,                        // Low: torque off
   output logic irq                               // Interrupt level
);
   import ssp_pkg::*;

   ////////////////////////////////////////////////////////////////////
   // Register bus
   logic [31:0] cfg_r [NCFG];
   logic [31:0] cfg_nxt [NCFG];
   logic [NSTAT-1:0] stat_r, stat_nxt, evt;
   logic aw_h_r, aw_h_nxt, w_h_r, w_h_nxt;
   logic [7:0] aw_a_r, aw_a_nxt;
   logic [31:0] w_d_r, w_d_nxt;
   logic [3:0] w_s_r, w_s_nxt;
   logic bv_r, bv_nxt, rv_r, rv_nxt;
   logic [1:0] br_r, br_nxt, rr_r, rr_nxt;
   logic [31:0] rd_r, rd_nxt;
   logic rd_stat;
   logic [31:0] pos_r;
   logic [15:0] speed_r;
   ssp_stop_e st_r, st_nxt;
   logic still_r, aux_ok_r, shp_arm_r;

   assign awready = !aw_h_r && !bv_r;
   assign wready = !w_h_r && !bv_r;
   assign arready = !rv_r;
   assign bvalid = bv_r;
   assign bresp = br_r;
   assign rvalid = rv_r;
   assign rresp = rr_r;
   assign rdata = rd_r;
   assign rd_stat = arvalid && arready && araddr == A_STAT;

   always_comb begin
      aw_h_nxt = aw_h_r;
      aw_a_nxt = aw_a_r;
      w_h_nxt = w_h_r;
      w_d_nxt = w_d_r;
      w_s_nxt = w_s_r;
      bv_nxt = bv_r && !bready;
      br_nxt = br_r;
      rv_nxt = rv_r && !rready;
      rr_nxt = rr_r;
      rd_nxt = rd_r;
      cfg_nxt = cfg_r;
      if (awvalid && awready) begin
         aw_h_nxt = 1'b1;
         aw_a_nxt = awaddr;
      end
      if (wvalid && wready) begin
         w_h_nxt = 1'b1;
         w_d_nxt = wdata;
         w_s_nxt = wstrb;
      end
      if (aw_h_r && w_h_r) begin
         aw_h_nxt = 1'b0;
         w_h_nxt = 1'b0;
         bv_nxt = 1'b1;
         br_nxt = RESP_OK;
         if (aw_a_r[1:0] == 2'b00 && aw_a_r <= A_MASK) begin
            for (int i = 0; i < 4; i++) begin
               if (w_s_r[i]) begin
                  cfg_nxt[aw_a_r[5:2]][8*i +: 8] = w_d_r[8*i +: 8];
               end
            end
         end else if (aw_a_r != A_STAT && aw_a_r != A_STATE &&
                      aw_a_r != A_POS && aw_a_r != A_SPEED) begin
            br_nxt = RESP_ERR;
         end
      end
      if (arvalid && arready) begin
         rv_nxt = 1'b1;
         rr_nxt = RESP_OK;
         rd_nxt = 32'h0000_0000;
         if (araddr[1:0] == 2'b00 && araddr <= A_MASK) begin
            rd_nxt = cfg_r[araddr[5:2]];
         end else if (araddr == A_STAT) begin
            rd_nxt = 32'(stat_r);
         end else if (araddr == A_STATE) begin
            rd_nxt = {25'h0, shp_arm_r, aux_ok_r, still_r,
                      st_r, torque_on, pos_mon_on};
         end else if (araddr == A_POS) begin
            rd_nxt = pos_r;
         end else if (araddr == A_SPEED) begin
            rd_nxt = {16'h0, speed_r};
         end else begin
            rr_nxt = RESP_ERR;
         end
      end
      // A new event wins over the clear by read
      stat_nxt = (rd_stat ? '0 : stat_r) | evt;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_h_r <= 1'b0;
         aw_a_r <= 8'h00;
         w_h_r <= 1'b0;
         w_d_r <= 32'h0000_0000;
         w_s_r <= 4'h0;
         bv_r <= 1'b0;
         br_r <= RESP_OK;
         rv_r <= 1'b0;
         rr_r <= RESP_OK;
         rd_r <= 32'h0000_0000;
         stat_r <= '0;
         for (int i = 0; i < NCFG; i++) begin
            cfg_r[i] <= CFG_RST;
         end
      end else begin
         aw_h_r <= aw_h_nxt;
         aw_a_r <= aw_a_nxt;
         w_h_r <= w_h_nxt;
         w_d_r <= w_d_nxt;
         w_s_r <= w_s_nxt;
         bv_r <= bv_nxt;
         br_r <= br_nxt;
         rv_r <= rv_nxt;
         rr_r <= rr_nxt;
         rd_r <= rd_nxt;
         stat_r <= stat_nxt;
         cfg_r <= cfg_nxt;
      end
   end

   assign irq = |(stat_r & cfg_r[I_MASK][NSTAT-1:0]);

   ////////////////////////////////////////////////////////////////////
   // Track capture and counting
   logic [3:0] trk_s;
   logic a, b, z, a_p_r, b_p_r, z_p_r, da, db, a_rise, z_rise;
   logic [31:0] ctrl, vlim;
   logic [15:0] ratio, thr, hyst, vcut;
   logic prox, ge_one;

   ssp_sync #(.W(4)) u_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .d({trk_aux, trk_z, trk_b, trk_a}),
      .q(trk_s)
   );

   assign ctrl = cfg_r[I_CTRL];
   assign vlim = cfg_r[I_VLIM];
   assign thr = cfg_r[I_STHR][15:0];
   assign hyst = cfg_r[I_HYST][15:0];
   assign vcut = cfg_r[I_VCUT][15:0];
   assign ratio = cfg_r[I_RATIO][15:0];
   assign prox = ctrl[C_PROX];
   assign ge_one = ratio >= RATIO_ONE;
   assign a = trk_s[0] ^ ctrl[C_POLA];
   assign b = trk_s[1] ^ ctrl[C_POLB];
   assign z = trk_s[2] && ctrl[C_IDX];
   assign da = a ^ a_p_r;
   assign db = b ^ b_p_r;
   assign a_rise = a && !a_p_r;
   assign z_rise = z && !z_p_r;

   logic [31:0] pos_nxt, win_r, win_nxt;
   logic [15:0] edg_r, edg_nxt, speed_nxt, ab_r, ab_nxt;
   logic [35:0] idle_r, idle_nxt;

   always_comb begin
      pos_nxt = pos_r;
      if ((da ^ db) && !prox) begin
         pos_nxt = (a ^ b_p_r) ? pos_r + 32'h1 : pos_r - 32'h1;
      end
      edg_nxt = (da || db) && edg_r != 16'hffff ? edg_r + 16'h1 : edg_r;
      win_nxt = win_r + 32'h1;
      speed_nxt = speed_r;
      if (win_r >= 32'(WIN_CYCLES - 1)) begin
         win_nxt = 32'h0;
         speed_nxt = edg_nxt;
         edg_nxt = 16'h0;
      end
      // Time since last edge on the side that sets minimum speed
      idle_nxt = idle_r != 36'hf_ffff_ffff ? idle_r + 36'h1 : idle_r;
      if (ge_one ? z_rise : (da || db)) begin
         idle_nxt = 36'h0;
      end
      ab_nxt = a_rise && ab_r != 16'hffff ? ab_r + 16'h1 : ab_r;
      if (z_rise) begin
         ab_nxt = 16'h0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         a_p_r <= 1'b0;
         b_p_r <= 1'b0;
         z_p_r <= 1'b0;
         pos_r <= 32'h0;
         edg_r <= 16'h0;
         win_r <= 32'h0;
         speed_r <= 16'h0;
         idle_r <= 36'hf_ffff_ffff;
         ab_r <= 16'h0;
      end else begin
         a_p_r <= a;
         b_p_r <= b;
         z_p_r <= z;
         pos_r <= pos_nxt;
         edg_r <= edg_nxt;
         win_r <= win_nxt;
         speed_r <= speed_nxt;
         idle_r <= idle_nxt;
         ab_r <= ab_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Plausibility, shearpin and auxiliary checks
   logic pls_err, shp_err, aux_err, tol_exc, still_nxt, aux_ok_nxt;
   logic min_ok, arm_nxt;
   logic [16:0] thr_up, vhi, vlo;

   assign pls_err = speed_r >= vcut &&
      (prox ? (!a && !b) : (da && db));
   assign min_ok = idle_r < 36'(MIN_CYCLES);
   assign tol_exc = ge_one ? {ab_r, 9'h0} > 25'(ratio) * 25'(TOL_HI_X2)
      : {ab_r, 1'b0} > 17'(TOL_LO_X2);
   assign arm_nxt = ctrl[C_IDX] && min_ok;
   assign shp_err = shp_arm_r && arm_nxt && a_rise && tol_exc;
   assign thr_up = {1'b0, thr} + {1'b0, hyst};
   assign vhi = {5'h0, vlim[27:16]} + (aux_ok_r ? {1'b0, hyst} : 17'h0);
   assign vlo = {5'h0, vlim[11:0]};
   assign aux_err = ctrl[C_AUXE] ? trk_s[3] : !aux_ok_r;
   assign evt[S_PLS] = pls_err;
   assign evt[S_SHP] = shp_err;
   assign evt[S_AUX] = aux_err;
   assign evt[S_POS] = st_r == ST_HOLD && st_nxt == ST_TRIP;

   always_comb begin
      // Standstill latched until speed rises past threshold plus band
      still_nxt = still_r ? ({1'b0, speed_r} <= thr_up)
         : (speed_r < thr);
      // While in range, band widens the limits before flagging
      aux_ok_nxt = {5'h0, aux_volt} <= vhi &&
         ({5'h0, aux_volt} + (aux_ok_r ? {1'b0, hyst} : 17'h0)) >= vlo;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         still_r <= 1'b0;
         aux_ok_r <= 1'b1;
         shp_arm_r <= 1'b0;
      end else begin
         still_r <= still_nxt;
         aux_ok_r <= aux_ok_nxt;
         shp_arm_r <= arm_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Controlled stop sequence
   logic [31:0] dly_r, dly_nxt, hold_r, hold_nxt, dev, lim;
   logic [32:0] dly_inc;
   logic go_hold, pos_out;

   assign dly_inc = {1'b0, dly_r} + 33'h1;
   // Delay expiry always ends braking; a threshold may end it sooner
   assign go_hold = dly_inc >= {1'b0, cfg_r[I_DELAY]} ||
      (thr != 16'h0 && still_r);
   assign dev = pos_r - hold_r;
   assign lim = cfg_r[I_TOL] + {16'h0, hyst};
   assign pos_out = (dev[31] ? 32'h0 - dev : dev) > lim;

   always_comb begin
      st_nxt = st_r;
      dly_nxt = st_r == ST_BRAKE ? dly_inc[31:0] : 32'h0;
      hold_nxt = hold_r;
      unique case (st_r)
         ST_IDLE: begin
            if (ctrl[C_STOP]) begin
               st_nxt = ST_BRAKE;
            end
         end
         ST_BRAKE: begin
            if (go_hold) begin
               st_nxt = ST_HOLD;
               hold_nxt = pos_r;
            end
         end
         ST_HOLD: begin
            if (pos_out) begin
               st_nxt = ST_TRIP;
            end
         end
         ST_TRIP: begin
            st_nxt = ST_TRIP;
         end
      endcase
      if (!ctrl[C_STOP]) begin
         st_nxt = ST_IDLE;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_r <= ST_IDLE;
         dly_r <= 32'h0;
         hold_r <= 32'h0;
      end else begin
         st_r <= st_nxt;
         dly_r <= dly_nxt;
         hold_r <= hold_nxt;
      end
   end

   assign brake_ramp_on = st_r == ST_IDLE;
   assign pos_mon_on = st_r == ST_HOLD;
   assign torque_on = st_r != ST_TRIP;

   ////////////////////////////////////////////////////////////////////
   // Checks
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);

   brake_off_a: assert property (
      st_r == ST_IDLE && ctrl[C_STOP] |=> !brake_ramp_on)
      else $error("braking ramp not started");
   hold_on_a: assert property (
      st_r == ST_BRAKE ##1 st_r == ST_HOLD |-> pos_mon_on && torque_on)
      else $error("hold entry outputs wrong");
   delay_exp_a: assert property (
      st_r == ST_BRAKE && thr == 16'h0 && ctrl[C_STOP] &&
      dly_inc >= {1'b0, cfg_r[I_DELAY]} |=> st_r == ST_HOLD)
      else $error("hold not started at delay expiry");
   still_go_a: assert property (
      st_r == ST_BRAKE && thr != 16'h0 && still_r && ctrl[C_STOP]
      |=> st_r == ST_HOLD && hold_r == $past(pos_r))
      else $error("hold not started at standstill");
   pos_trip_a: assert property (
      st_r == ST_HOLD && pos_out && ctrl[C_STOP]
      |=> !torque_on && !pos_mon_on && stat_r[S_POS])
      else $error("torque not removed");
   pls_suspend_a: assert property (
      speed_r < vcut |-> !evt[S_PLS])
      else $error("plausibility not suspended");
   shear_arm_a: assert property (
      evt[S_SHP] |-> $past(min_ok) && min_ok && tol_exc)
      else $error("shearpin reported before armed");
   aux_err_a: assert property (
      ctrl[C_AUXE] && trk_s[3] |=> stat_r[S_AUX])
      else $error("encoder error not flagged");
   irq_lvl_a: assert property (
      irq == |(stat_r & cfg_r[I_MASK][NSTAT-1:0]))
      else $error("interrupt level wrong");

   hold_c: cover property (st_r == ST_BRAKE ##1 st_r == ST_HOLD);
   trip_c: cover property (st_r == ST_HOLD ##1 st_r == ST_TRIP);
   shear_c: cover property (evt[S_SHP]);
endmodule

// File: testbench/ssp_sensor_model.sv
// Behavioural encoder, proximity pair and index switch of one axis
`timescale 1ns/10ps
module ssp_sensor_model (
   input wire logic aclk,       // Clock
   input wire logic aresetn,    // Sync reset, low
   input wire logic stp,        // One step per high sample
   input wire logic dir,        // Step direction
   input wire logic prox,       // Proximity pair instead of encoder
   input wire logic gap,        // Both switches inactive on purpose
   input wire logic inv_a,      // Track A switch is active low
   input wire logic inv_b,      // Track B switch is active low
   input wire logic idx_en,     // Index switch fitted
   input wire logic zin,        // Index switch level
   input wire logic err,        // Encoder error output
   output logic trk_a,          // Track A
   output logic trk_b,          // Track B
   output logic trk_z,          // Index track
   output logic trk_aux         // Auxiliary track
);
   logic [1:0] ph_r;
   logic [1:0] act;
   ////////////////////////////////////////
   always_ff @(posedge aclk) begin
      if (!aresetn)
         ph_r <= 2'h0;
      else if (stp)
         ph_r <= dir ? ph_r + 2'h1 : ph_r - 2'h1;
   end
   // Switches overlap: never both inactive unless a gap is commanded
   always_comb begin
      if (!prox)
         act = {ph_r[1], ph_r[1] ^ ph_r[0]};
      else if (gap)
         act = 2'b00;
      else
         act = {ph_r != 2'h2, ph_r != 2'h0};
   end
   assign trk_a = act[1] ^ inv_a;
   assign trk_b = act[0] ^ inv_b;
   // Unused index input reads as pulled low
   assign trk_z = idx_en & zin;
   assign trk_aux = err;
endmodule

// File: testbench/tb_ssp_top.sv
// Self-checking bench for the stop and plausibility monitor
`timescale 1ns/10ps
module tb_ssp_top;
   import ssp_pkg::*;
   logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, trk_a, trk_b, trk_z, trk_aux;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata, rd;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp;
   logic [11:0] aux_volt;
   logic brake_ramp_on, pos_mon_on, torque_on, irq;
   logic stp, dir, prox, gap, inv_a, inv_b, idx_en, zin, err;
   int bad_count, tests_run, brk_cyc;
   ssp_top #(.WIN_CYCLES(64), .MIN_CYCLES(2000)) u_ssp_top (.aclk, .aresetn,
      .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
      .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
      .rready, .trk_a, .trk_b, .trk_z, .trk_aux, .aux_volt, .brake_ramp_on,
      .pos_mon_on, .torque_on, .irq);
   ssp_sensor_model u_ssp_sensor_model (.aclk, .aresetn, .stp, .dir, .prox,
      .gap, .inv_a, .inv_b, .idx_en, .zin, .err, .trk_a, .trk_b, .trk_z,
      .trk_aux);
   ////////////////////////////////////////
   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   // Counts braking cycles before hold monitoring starts
   always @(posedge aclk) begin
      if (brake_ramp_on !== 1'b0)
         brk_cyc <= 0;
      else if (pos_mon_on === 1'b0)
         brk_cyc <= brk_cyc + 1;
   end
   task automatic chk(input string nm, input logic [31:0] seen,
                      input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic tally_and_finish;
      if (bad_count == 0 && tests_run > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge aclk);
   endtask
   task automatic axw(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er);
      int n;
      n = 0;
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hf;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (awvalid && awready)
            awvalid <= 1'b0;
         if (wvalid && wready)
            wvalid <= 1'b0;
      end while (!bvalid && n < 50);
      chk("bresp", {bvalid, bresp}, {1'b1, er});
      bready <= 1'b0;
      @(posedge aclk);
   endtask
   task automatic axr(input logic [7:0] a, output logic [31:0] d,
                      input logic [1:0] er);
      int n;
      n = 0;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (arvalid && arready)
            arvalid <= 1'b0;
      end while (!rvalid && n < 50);
      d = rdata;
      chk("rresp", {rvalid, rresp}, {1'b1, er});
      rready <= 1'b0;
      @(posedge aclk);
   endtask
   task automatic move(input int n, input logic d);
      repeat (n) begin
         stp <= 1'b1;
         dir <= d;
         @(posedge aclk);
         stp <= 1'b0;
         @(posedge aclk);
      end
   endtask
   task automatic waitpos(input int lim);
      int n;
      n = 0;
      while (pos_mon_on !== 1'b1 && n < lim) begin
         @(posedge aclk);
         n++;
      end
   endtask
   task automatic zpulse;
      zin <= 1'b1;
      cyc(4);
      zin <= 1'b0;
      cyc(4);
   endtask
   // Largest count of A rises between index pulses not above the tolerance
   function automatic int shp_limit(input logic [15:0] r);
      return (r >= RATIO_ONE) ? (int'(r) * 15) / 512 : 4;
   endfunction
   ////////////////////////////////////////
   initial begin
      int d, t, h;
      logic [15:0] rt [3] = '{16'h0080, 16'h0100, 16'h0180};
      logic [11:0] av [3] = '{12'h063, 12'h096, 12'h0c9};
      {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
      {stp, dir, prox, gap, inv_a, inv_b, idx_en, zin, err} = 9'h000;
      {awaddr, araddr, wdata, wstrb, aux_volt} = 64'h0;
      rd = $urandom(76);
      cyc(2);
      aresetn <= 1'b1;
      cyc(1);
      chk("reset outs", {brake_ramp_on, pos_mon_on, torque_on, irq}, 4'ha);
      for (int i = 0; i <= NCFG; i++) begin
         axr(8'(4 * i), rd, RESP_OK);
         chk("reg reset", rd, CFG_RST);
      end
      axr(8'h40, rd, RESP_ERR);
      chk("unmapped rdata", rd, 32'h0);
      axw(8'h44, 32'h1, RESP_ERR);
      axw(A_STAT, 32'hf, RESP_OK);
      axw(A_VLIM, 32'h0fff_0000, RESP_OK);
      d = $urandom;
      axw(A_VCUT, 32'(d), RESP_OK);
      axr(A_VCUT, rd, RESP_OK);
      chk("vcut", rd[15:0], d[15:0]);
      axw(A_VCUT, 32'h0, RESP_OK);
      // Stop by delay, then leave the standstill window
      d = 1 + $urandom % 40;
      t = 1 + $urandom % 10;
      h = $urandom % 6;
      aux_volt <= 12'($urandom);
      axw(A_DELAY, 32'(d), RESP_OK);
      axw(A_TOL, 32'(t), RESP_OK);
      axw(A_HYST, 32'(h), RESP_OK);
      axw(A_CTRL, 32'h1, RESP_OK);
      chk("brake off", brake_ramp_on, 1'b0);
      waitpos(100);
      chk("hold delay", brk_cyc, d);
      chk("hold on", {pos_mon_on, torque_on}, 2'h3);
      dir <= 1'($urandom);
      cyc(1);
      move(t + h, dir);
      cyc(8);
      chk("inside window", {torque_on, pos_mon_on}, 2'h3);
      move(1, dir);
      cyc(8);
      chk("trip", {brake_ramp_on, torque_on, pos_mon_on}, 3'h0);
      chk("irq masked", irq, 1'b0);
      axw(A_MASK, 32'h1, RESP_OK);
      cyc(2);
      chk("irq raised", irq, 1'b1);
      axr(A_STAT, rd, RESP_OK);
      chk("pos event", rd[0], 1'b1);
      cyc(2);
      chk("irq cleared", irq, 1'b0);
      axr(A_STAT, rd, RESP_OK);
      chk("stat cleared", rd[0], 1'b0);
      axw(A_MASK, 32'h0, RESP_OK);
      axw(A_CTRL, 32'h0, RESP_OK);
      cyc(3);
      chk("idle", {brake_ramp_on, torque_on, pos_mon_on}, 3'h6);
      // Stop by standstill threshold while moving
      axw(A_STHR, 32'h4, RESP_OK);
      axw(A_DELAY, 32'h0000_0bb8, RESP_OK);
      fork
         move(200, 1'b1);
         begin
            cyc(200);
            axw(A_CTRL, 32'h1, RESP_OK);
         end
      join
      chk("no hold moving", pos_mon_on, 1'b0);
      waitpos(400);
      chk("early hold", {pos_mon_on, brk_cyc < 3000}, 2'h3);
      axw(A_CTRL, 32'h0, RESP_OK);
      axw(A_STHR, 32'h0, RESP_OK);
      // Proximity pair in all polarities, then with checking suspended
      for (int i = 0; i < 4; i++) begin
         inv_a <= i[0];
         inv_b <= i[1];
         prox <= 1'b1;
         axw(A_CTRL, 32'h10 | (32'(i) << 2), RESP_OK);
         cyc(10);
         axr(A_STAT, rd, RESP_OK);
         move(12, 1'b1);
         axr(A_STAT, rd, RESP_OK);
         chk("plaus clean", rd[1], 1'b0);
         if (i == 3)
            axw(A_VCUT, 32'h0000_ffff, RESP_OK);
         gap <= 1'b1;
         cyc(10);
         gap <= 1'b0;
         cyc(10);
         axr(A_STAT, rd, RESP_OK);
         chk("plaus fault", rd[1], i != 3);
      end
      {prox, inv_a, inv_b} <= 3'h0;
      axw(A_VCUT, 32'h0, RESP_OK);
      // Auxiliary track as error input and as voltage monitor
      err <= 1'b1;
      axw(A_CTRL, 32'h20, RESP_OK);
      err <= 1'b0;
      cyc(6);
      axr(A_STAT, rd, RESP_OK);
      chk("enc error", rd[3], 1'b1);
      axw(A_CTRL, 32'h0, RESP_OK);
      axw(A_HYST, 32'h0, RESP_OK);
      axw(A_VLIM, 32'h00c8_0064, RESP_OK);
      foreach (av[i]) begin
         aux_volt <= av[i];
         cyc(4);
         axr(A_STAT, rd, RESP_OK);
         axr(A_STAT, rd, RESP_OK);
         chk("aux range", rd[3], av[i] != 12'h096);
      end
      axw(A_VLIM, 32'h0fff_0000, RESP_OK);
      // Index switch against quadrature at three ratios
      foreach (rt[i]) begin
         axw(A_RATIO, 32'(rt[i]), RESP_OK);
         axw(A_CTRL, 32'h2, RESP_OK);
         idx_en <= 1'b1;
         zpulse();
         axr(A_STAT, rd, RESP_OK);
         repeat (3) begin
            move(4 * shp_limit(rt[i]), 1'b1);
            zpulse();
         end
         axr(A_STAT, rd, RESP_OK);
         chk("shearpin clean", rd[2], 1'b0);
         move(4 * shp_limit(rt[i]) + 8, 1'b1);
         axr(A_STAT, rd, RESP_OK);
         chk("shearpin fault", rd[2], 1'b1);
      end
      idx_en <= 1'b0;
      axw(A_CTRL, 32'h0, RESP_OK);
      tally_and_finish();
   end
   initial begin
      repeat (30000) @(posedge aclk);
      bad_count++;
      tally_and_finish();
   end
endmodule
